//--- src/zts_burst_ctr.sv
// Two-bit burst counter with linear or interleaved order.
`include "zts_defines.svh"
module zts_burst_ctr (
    input wire logic core_clk_in, // System clock.
    input wire logic rst_n_in, // Synchronised reset, active low.
    input wire logic load_in, // Load a new start value.
    input wire logic step_in, // Advance the counter by one.
    input wire logic interleave_in, // High selects interleaved order.
    input wire logic [`ZTS_BURST_W-1:0] start_in, // External start bits.
    output logic [`ZTS_BURST_W-1:0] addr_out // Current burst address bits.
);
    logic [`ZTS_BURST_W-1:0] start; // Latched start value.
    logic [`ZTS_BURST_W-1:0] count; // Steps taken since the load.
    logic [`ZTS_BURST_W-1:0] next_count; // Count after one step.

    // The count wraps modulo four.
    assign next_count = count + `ZTS_BURST_ONE;

    // Start and count are loaded or stepped on qualified edges only.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            start <= `ZTS_CNT_ZERO;
            count <= `ZTS_CNT_ZERO;
        end else if (load_in) begin
            start <= start_in;
            count <= `ZTS_CNT_ZERO;
        end else if (step_in) begin
            count <= next_count;
        end
    end

    // Interleaved order is start XOR count; linear is start plus count.
    assign addr_out = interleave_in ? (start ^ count) : (start + count);
endmodule

//--- src/zts_defines.svh
// Constants for the zero-turnaround synchronous SRAM controller.
`ifndef ZTS_DEFINES_SVH
`define ZTS_DEFINES_SVH
`define ZTS_ADDR_W 19
`define ZTS_LANES 2
`define ZTS_LANE_W 9
`define ZTS_DATA_W 18
`define ZTS_DEPTH 524288
`define ZTS_FIFO_DEPTH 32
`define ZTS_BURST_W 2
`define ZTS_BURST_ONE 2'h1
`define ZTS_CNT_ZERO 2'h0
`define ZTS_SYNC_W 3
`define ZTS_PIPE_DEPTH 2
`endif

//--- src/zts_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
module zts_fifo #(
    parameter int WIDTH = 18, // Word width.
    parameter int DEPTH = 32 // Number of words.
) (
    input wire logic core_clk_in, // System clock.
    input wire logic rst_n_in, // Synchronised reset, active low.
    input wire logic in_valid_in, // Word offered on the fill side.
    output logic in_ready_out, // FIFO can take a word.
    input wire logic [WIDTH-1:0] in_data_in, // Word to store.
    output logic out_valid_out, // A word is available.
    input wire logic out_ready_in, // Drain side takes the word.
    output logic [WIDTH-1:0] out_data_out // Oldest word.
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH]; // Storage array.
    logic [AW-1:0] wr_ptr; // Next slot to write.
    logic [AW-1:0] rd_ptr; // Next slot to read.
    logic [AW:0] fill; // Words held.
    logic push; // Word accepted this cycle.
    logic pop; // Word removed this cycle.

    assign in_ready_out = (fill != DEPTH[AW:0]);
    assign out_valid_out = (fill != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem[rd_ptr];

    // Storage is written without reset.
    always_ff @(posedge core_clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    // Pointers and fill level follow pushes and pops.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            fill <= fill + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule

//--- src/zts_pkg.sv
// Types shared by the zero-turnaround synchronous SRAM controller.
`include "zts_defines.svh"
package zts_pkg;
    // Input command decoded on each edge.
    typedef enum logic [2:0] {
        ZTS_CMD_DESEL = 3'h0,
        ZTS_CMD_READ = 3'h1,
        ZTS_CMD_WRITE = 3'h3,
        ZTS_CMD_BURST = 3'h2,
        ZTS_CMD_HOLD = 3'h6
    } zts_cmd_e;
    // Kind of access the array performs in one cycle.
    typedef enum logic [1:0] {
        ZTS_OP_IDLE = 2'h0,
        ZTS_OP_RD = 2'h1,
        ZTS_OP_WR = 2'h3
    } zts_op_e;
    // One array operation travelling through the data pipeline.
    typedef struct packed {
        zts_op_e op;
        logic [`ZTS_ADDR_W-1:0] addr;
        logic [`ZTS_LANES-1:0] byte_en;
    } zts_req_s;
endpackage

//--- src/zts_sram_ctrl.sv
// Control logic and array of the zero-turnaround synchronous SRAM.
`include "zts_defines.svh"
module zts_sram_ctrl (
    input wire logic core_clk_in, // System clock.
    input wire logic rstn_in, // Asynchronous reset, active low.
    input wire logic clk_en_n_in, // Clock enable, active low.
    input wire logic chip_sel_a_n_in, // Chip select a, active low.
    input wire logic chip_sel_b_in, // Chip select b, active high.
    input wire logic chip_sel_c_n_in, // Chip select c, active low.
    input wire logic write_n_in, // Write command, active low.
    input wire logic load_advance_n_in, // Low loads, high advances.
    input wire logic [`ZTS_LANES-1:0] byte_write_en_n_in, // Byte write enables, active low.
    input wire logic [`ZTS_ADDR_W-3:0] addr_in, // Upper address bits.
    input wire logic burst_addr_bit0_in, // Address bit 0.
    input wire logic burst_addr_bit1_in, // Address bit 1.
    input wire logic output_en_n_in, // Asynchronous output enable, active low.
    input wire logic flow_through_strap_n_in, // Low flow-through, high pipelined.
    input wire logic burst_order_strap_n_in, // Low linear, high interleaved.
    input wire logic [`ZTS_DATA_W-1:0] data_lane_in, // Data bus level seen at the pins.
    output logic [`ZTS_DATA_W-1:0] data_lane_out, // Read data driven to the bus.
    output logic data_lane_oe_n_out, // Low while the device drives the bus.
    input wire logic rd_ready_in, // Read stream consumer is ready.
    output logic rd_valid_out, // Read stream word valid.
    output logic [`ZTS_DATA_W-1:0] rd_data_out, // Read stream word.
    output logic rd_overflow_out // Sticky: read word dropped at a full FIFO.
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync; // Two-stage reset release.
    logic rst_n; // Synchronised reset.

    // Reset asserts at once and releases after two edges.
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ------------------------------------------------------------
    // Input registers
    // ------------------------------------------------------------
    logic clk_en_n_q; // Registered clock enable.
    logic sel_q; // Registered chip-select decode.
    logic write_n_q; // Registered write input.
    logic load_n_q; // Registered load/advance.
    logic [`ZTS_LANES-1:0] bwe_n_q; // Registered byte enables.
    logic [`ZTS_ADDR_W-1:0] addr_q; // Registered full address.
    logic [`ZTS_DATA_W-1:0] din_q; // Registered write data.
    logic cap_valid; // A capture has occurred since reset.

    // Every edge captures the synchronous inputs; straps and output enable are not captured.
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            clk_en_n_q <= 1'b1;
            sel_q <= 1'b0;
            write_n_q <= 1'b1;
            load_n_q <= 1'b0;
            bwe_n_q <= '1;
            addr_q <= '0;
            din_q <= '0;
            cap_valid <= 1'b0;
        end else begin
            clk_en_n_q <= clk_en_n_in;
            sel_q <= !chip_sel_a_n_in && chip_sel_b_in && !chip_sel_c_n_in;
            write_n_q <= write_n_in;
            load_n_q <= load_advance_n_in;
            bwe_n_q <= byte_write_en_n_in;
            addr_q <= {addr_in, burst_addr_bit1_in, burst_addr_bit0_in};
            din_q <= data_lane_in;
            cap_valid <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    zts_pkg::zts_cmd_e cmd; // Command of the registered cycle.
    zts_pkg::zts_op_e last_op; // Type of the previous operation.

    // Advance cycles look only at enable, byte enables and load/advance.
    always_comb begin
        if (!cap_valid || clk_en_n_q) begin
            cmd = zts_pkg::ZTS_CMD_HOLD;
        end else if (load_n_q) begin
            cmd = zts_pkg::ZTS_CMD_BURST;
        end else if (!sel_q) begin
            cmd = zts_pkg::ZTS_CMD_DESEL;
        end else if (!write_n_q) begin
            cmd = zts_pkg::ZTS_CMD_WRITE;
        end else begin
            cmd = zts_pkg::ZTS_CMD_READ;
        end
    end

    // The previous operation type is remembered for burst continue.
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            last_op <= zts_pkg::ZTS_OP_IDLE;
        end else begin
            case (cmd)
                zts_pkg::ZTS_CMD_WRITE: last_op <= zts_pkg::ZTS_OP_WR;
                zts_pkg::ZTS_CMD_READ: last_op <= zts_pkg::ZTS_OP_RD;
                zts_pkg::ZTS_CMD_DESEL: last_op <= zts_pkg::ZTS_OP_IDLE;
                default: last_op <= last_op;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Burst addressing
    // ------------------------------------------------------------
    logic load_addr; // New read or write loads the counter.
    logic step_addr; // Burst continue of a read or write.
    logic [`ZTS_BURST_W-1:0] burst_lo; // Counter output bits.
    logic [`ZTS_ADDR_W-3:0] addr_hi; // Latched upper address.

    assign load_addr = (cmd == zts_pkg::ZTS_CMD_WRITE) || (cmd == zts_pkg::ZTS_CMD_READ);
    assign step_addr = (cmd == zts_pkg::ZTS_CMD_BURST) && (last_op != zts_pkg::ZTS_OP_IDLE);

    // The counter is loaded on new accesses and stepped on bursts.
    zts_burst_ctr u_burst (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n),
        .load_in(load_addr),
        .step_in(step_addr),
        .interleave_in(burst_order_strap_n_in),
        .start_in(addr_q[`ZTS_BURST_W-1:0]),
        .addr_out(burst_lo)
    );

    // The upper address is kept for the whole burst.
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            addr_hi <= '0;
        end else if (load_addr) begin
            addr_hi <= addr_q[`ZTS_ADDR_W-1:`ZTS_BURST_W];
        end
    end

    // ------------------------------------------------------------
    // Operation pipeline
    // ------------------------------------------------------------
    zts_pkg::zts_req_s cur_req; // Operation issued this cycle.
    zts_pkg::zts_req_s pipe [`ZTS_PIPE_DEPTH]; // Delay line to the data phase.
    zts_pkg::zts_req_s data_req; // Operation in its data phase.
    logic issued; // The operation of the previous cycle was real.
    logic [`ZTS_ADDR_W-1:0] cur_addr; // Address of the operation.
    logic [`ZTS_LANES-1:0] cur_bwe_n; // Byte enables at issue.

    // Operations issue one cycle after their command once the counter holds the address.
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            issued <= 1'b0;
            cur_bwe_n <= '1;
        end else if (cmd != zts_pkg::ZTS_CMD_HOLD) begin
            issued <= load_addr || step_addr;
            cur_bwe_n <= bwe_n_q;
        end
    end

    assign cur_addr = {addr_hi, burst_lo};

    // The request carries byte enables only for writes.
    always_comb begin
        cur_req.addr = cur_addr;
        cur_req.op = issued ? last_op : zts_pkg::ZTS_OP_IDLE;
        cur_req.byte_en = (cur_req.op == zts_pkg::ZTS_OP_WR) ? ~cur_bwe_n : '0;
    end

    // The delay line stands still on held cycles.
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pipe[0] <= '{op: zts_pkg::ZTS_OP_IDLE, addr: '0, byte_en: '0};
            pipe[1] <= '{op: zts_pkg::ZTS_OP_IDLE, addr: '0, byte_en: '0};
        end else if (cmd != zts_pkg::ZTS_CMD_HOLD) begin
            pipe[0] <= cur_req;
            pipe[1] <= pipe[0];
        end
    end

    // Flow-through uses one stage of delay, pipelined uses two.
    assign data_req = flow_through_strap_n_in ? pipe[1] : pipe[0];

    // ------------------------------------------------------------
    // Memory array
    // ------------------------------------------------------------
    logic [`ZTS_DATA_W-1:0] mem [`ZTS_DEPTH]; // Storage array.
    logic [`ZTS_DATA_W-1:0] rd_word; // Word at the data-phase address.
    logic data_phase_go; // Data phase may act this cycle.

    assign data_phase_go = (cmd != zts_pkg::ZTS_CMD_HOLD);
    assign rd_word = mem[data_req.addr];

    // Each lane is written only when its own enable is active.
    always_ff @(posedge core_clk_in) begin
        if (data_phase_go && data_req.op == zts_pkg::ZTS_OP_WR) begin
            for (int i = 0; i < `ZTS_LANES; i++) begin
                if (data_req.byte_en[i]) begin
                    mem[data_req.addr][i*`ZTS_LANE_W +: `ZTS_LANE_W] <= din_q[i*`ZTS_LANE_W +: `ZTS_LANE_W];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Output register and bus drive
    // ------------------------------------------------------------
    logic [`ZTS_DATA_W-1:0] dout; // Read data register.
    logic dout_rd; // Register holds read data.

    // Read data is registered on every non-held cycle; dout_rd marks the data phase of a read.
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            dout <= '0;
            dout_rd <= 1'b0;
        end else if (data_phase_go) begin
            dout <= rd_word;
            dout_rd <= (data_req.op == zts_pkg::ZTS_OP_RD);
        end
    end

    assign data_lane_out = dout;
    // Bus is driven only for reads with the output enable low.
    assign data_lane_oe_n_out = !(dout_rd && !output_en_n_in);

    // ------------------------------------------------------------
    // Read stream buffer
    // ------------------------------------------------------------
    logic rd_push; // New read word offered to the FIFO.
    logic fifo_ready; // FIFO has room.

    assign rd_push = data_phase_go && (data_req.op == zts_pkg::ZTS_OP_RD);

    // Read words are also offered as a stream through the FIFO.
    zts_fifo #(
        .WIDTH(`ZTS_DATA_W),
        .DEPTH(`ZTS_FIFO_DEPTH)
    ) u_fifo (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n),
        .in_valid_in(rd_push),
        .in_ready_out(fifo_ready),
        .in_data_in(rd_word),
        .out_valid_out(rd_valid_out),
        .out_ready_in(rd_ready_in),
        .out_data_out(rd_data_out)
    );

    // A read word that finds the FIFO full is reported by a sticky flag.
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rd_overflow_out <= 1'b0;
        end else if (rd_push && !fifo_ready) begin
            rd_overflow_out <= 1'b1;
        end
    end
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the synchronous SRAM controller.
`include "zts_defines.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Signals and bench model state
    // ----------------------------------------
    logic clk = 1'b0, rstn = 1'b0, cke_n = 1'b0, ld_n = 1'b0, wr_n = 1'b1, oe_g_n = 1'b1;
    logic cs_a_n = 1'b1, cs_b = 1'b0, cs_c_n = 1'b1, ft_n = 1'b0, bo_n = 1'b0, rdy = 1'b0;
    logic hdrv = 1'b0, stall = 1'b0, doe_n, rval, ovf;
    logic [1:0] be_n = 2'h0, lo = 2'h0;
    logic [16:0] ahi = 17'h0, base = 17'h0;
    logic [17:0] hdat = 18'h0, bus, dout, rdat;
    logic [17:0] mem [int]; // Expected array contents.
    logic [17:0] exp_q [$]; // Expected read stream.
    logic [17:0] bus_q [$]; // Expected read words at the data pins.
    logic h1 = 1'b0, h2 = 1'b0; // Clock-enable pin level one and two edges back.
    int error_cnt = 0, comparisons = 0;
    always #10 clk = ~clk;
    zts_sram_ctrl i_dut (.core_clk_in(clk), .rstn_in(rstn), .clk_en_n_in(cke_n),
        .chip_sel_a_n_in(cs_a_n), .chip_sel_b_in(cs_b), .chip_sel_c_n_in(cs_c_n),
        .write_n_in(wr_n), .load_advance_n_in(ld_n), .byte_write_en_n_in(be_n), .addr_in(ahi),
        .burst_addr_bit0_in(lo[0]), .burst_addr_bit1_in(lo[1]), .output_en_n_in(oe_g_n),
        .flow_through_strap_n_in(ft_n), .burst_order_strap_n_in(bo_n), .data_lane_in(bus),
        .data_lane_out(dout), .data_lane_oe_n_out(doe_n), .rd_ready_in(rdy),
        .rd_valid_out(rval), .rd_data_out(rdat), .rd_overflow_out(ovf));
    zts_bus_model i_bus (.core_clk_in(clk), .host_drive_in(hdrv), .host_data_in(hdat),
        .dev_oe_n_in(doe_n), .dev_data_in(dout), .bus_out(bus));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("Mismatches %0d, comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Burst position k from start s in the strapped order.
    function automatic logic [1:0] pos(input logic [1:0] s, input int k);
        return bo_n ? (s ^ 2'(k)) : (s + 2'(k));
    endfunction
    // One command cycle; an unselected command picks any of the seven off codes.
    task automatic cmd(input logic h, input logic l, input logic w, input logic s, input logic [1:0] b,
        input logic [1:0] p);
        logic [2:0] c;
        c = 3'h2;
        while (!s && c == 3'h2) c = 3'($urandom);
        cke_n <= h;
        ld_n <= l;
        wr_n <= w;
        {cs_a_n, cs_b, cs_c_n} <= c;
        be_n <= b;
        lo <= l ? 2'($urandom) : p;
        ahi <= l ? 17'($urandom) : base;
        @(posedge clk);
    endtask
    // Burst of n beats with data d held on the bus; on low makes the first beat a deselect.
    task automatic wburst(input logic [17:0] d, input logic [1:0] s, input logic [7:0] bes, input logic on,
        input int n);
        hdrv <= 1'b1;
        hdat <= d;
        for (int k = 0; k < n; k++) begin
            cmd(1'b0, k != 0, k == 0 ? 1'b0 : 1'($urandom), k == 0 ? on : 1'($urandom), bes[2*(k%4)+:2], s);
            for (int j = 0; j < 2; j++) begin
                if (on && !bes[2*(k%4)+j]) mem[{base, pos(s, k)}][9*j+:9] = d[9*j+:9];
            end
        end
        repeat (5) cmd(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0);
        hdrv <= 1'b0;
    endtask
    // Read burst of n beats with random held runs and ignored inputs on advance beats.
    task automatic rburst(input logic [1:0] s, input int n);
        oe_g_n <= 1'b0;
        for (int k = 0; k < n; k++) begin
            if (!stall && $urandom % 4 == 0) begin
                repeat (3) cmd(1'b1, 1'($urandom), 1'($urandom), 1'($urandom), 2'($urandom), 2'h0);
            end
            cmd(1'b0, k != 0, k == 0 ? 1'b1 : 1'($urandom), k == 0 || 1'($urandom), 2'($urandom), s);
            exp_q.push_back(mem[{base, pos(s, k)}]);
            bus_q.push_back(mem[{base, pos(s, k)}]);
        end
        repeat (8) cmd(1'b0, 1'b0, 1'b1, 1'b0, 2'h0, 2'h0);
        oe_g_n <= 1'b1;
    endtask
    task automatic drain;
        for (int i = 0; i < 300 && exp_q.size() > 0; i++) @(posedge clk);
        check(18'(exp_q.size()), 18'h0);
        check(18'(bus_q.size()), 18'h0);
    endtask
    // ----------------------------------------
    // Consumer and read stream comparison
    // ----------------------------------------
    always @(posedge clk) begin
        rdy <= stall ? 1'b0 : 1'($urandom);
        h1 <= cke_n;
        h2 <= h1;
        // A word launched on a held edge is the old word standing on; it is compared only once.
        if (rstn && !doe_n && !h2) begin
            check(dout, bus_q.pop_front());
        end
        if (rstn && rval && rdy) begin
            check(rdat, exp_q.pop_front());
        end
    end
    // ----------------------------------------
    // Main sequence, one pass for each strap setting
    // ----------------------------------------
    initial begin
        void'($urandom(41));
        for (int m = 0; m < 4; m++) begin
            rstn <= 1'b0;
            {ft_n, bo_n} <= 2'(m);
            repeat (20) @(posedge clk);
            rstn <= 1'b1;
            repeat (3) @(posedge clk);
            base = 17'($urandom);
            wburst(18'($urandom), 2'h0, 8'h00, 1'b1, 4);
            wburst(18'($urandom), 2'($urandom), 8'(16'he4e4 >> (2 * ($urandom % 4))), 1'b1, 4);
            wburst(18'($urandom), 2'h0, 8'h00, 1'b0, 6);
            rburst(2'($urandom), 5);
            drain;
        end
        stall = 1'b1;
        rburst(2'($urandom), 34);
        check({17'h0, ovf}, 18'h1);
        while (exp_q.size() > 32) exp_q.pop_back();
        stall = 1'b0;
        drain;
        end_sim;
    end
    // Cuts a hang short well beyond the expected run of a few hundred cycles.
    initial begin
        #400000;
        error_cnt++;
        end_sim;
    end
endmodule
bind zts_sram_ctrl zts_sram_ctrl_props i_props (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .clk_en_n_in(clk_en_n_in), .chip_sel_a_n_in(chip_sel_a_n_in), .chip_sel_b_in(chip_sel_b_in),
    .chip_sel_c_n_in(chip_sel_c_n_in), .write_n_in(write_n_in), .load_advance_n_in(load_advance_n_in),
    .output_en_n_in(output_en_n_in), .data_lane_out(data_lane_out), .data_lane_oe_n_out(data_lane_oe_n_out),
    .rd_ready_in(rd_ready_in), .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
    .rd_overflow_out(rd_overflow_out));

//--- tb/zts_bus_model.sv
// Memory-controller side of the shared data bus, as a behavioural model.
`include "zts_defines.svh"
module zts_bus_model (
    input wire logic core_clk_in, // System clock.
    input wire logic host_drive_in, // Controller drives write data.
    input wire logic [`ZTS_DATA_W-1:0] host_data_in, // Write data.
    input wire logic dev_oe_n_in, // Device drive enable, active low.
    input wire logic [`ZTS_DATA_W-1:0] dev_data_in, // Device read data.
    output logic [`ZTS_DATA_W-1:0] bus_out // Resolved bus level.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [`ZTS_DATA_W-1:0] last = '0; // Level seen in the last cycle.
    // A floating bus must not keep its old value, so it shows the inverse each cycle.
    always_comb begin
        if (host_drive_in) begin
            bus_out = host_data_in;
        end else if (!dev_oe_n_in) begin
            bus_out = dev_data_in;
        end else begin
            bus_out = ~last;
        end
    end
    // Remembers the level so that the float pattern keeps changing.
    always_ff @(posedge core_clk_in) begin
        last <= bus_out;
    end
endmodule

//--- tb/zts_sram_ctrl_properties.sv
// Concurrent checks on the pins of the SRAM controller.
`include "zts_defines.svh"
module zts_sram_ctrl_props (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic clk_en_n_in,
    input wire logic chip_sel_a_n_in,
    input wire logic chip_sel_b_in,
    input wire logic chip_sel_c_n_in,
    input wire logic write_n_in,
    input wire logic load_advance_n_in,
    input wire logic output_en_n_in,
    input wire logic [`ZTS_DATA_W-1:0] data_lane_out,
    input wire logic data_lane_oe_n_out,
    input wire logic rd_ready_in,
    input wire logic rd_valid_out,
    input wire logic [`ZTS_DATA_W-1:0] rd_data_out,
    input wire logic rd_overflow_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Commands decoded at the pins
    // ----------------------------------------
    logic sel, c_ds, c_wr, c_rd, c_bu;
    assign sel = !chip_sel_a_n_in && chip_sel_b_in && !chip_sel_c_n_in;
    assign c_ds = !clk_en_n_in && !load_advance_n_in && !sel;
    assign c_wr = !clk_en_n_in && !load_advance_n_in && sel && !write_n_in;
    assign c_rd = !clk_en_n_in && !load_advance_n_in && sel && write_n_in;
    assign c_bu = !clk_en_n_in && load_advance_n_in;
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rstn_in);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_gate_blocks_bus: assert property (output_en_n_in |-> data_lane_oe_n_out)
        else $error("Bus driven while the output gate is off.");
    a_hold_freezes_out: assert property (clk_en_n_in [*3] ##1 $stable(output_en_n_in)
        |-> $stable(data_lane_out) && $stable(data_lane_oe_n_out))
        else $error("Read output moved during held cycles.");
    a_desel_keeps_quiet: assert property (c_ds [*6] |-> data_lane_oe_n_out)
        else $error("Bus driven while deselected.");
    a_desel_stays_off: assert property (c_ds ##1 c_bu [*5] |-> data_lane_oe_n_out)
        else $error("Advance after deselect drove the bus.");
    a_write_burst_quiet: assert property (c_wr ##1 c_bu [*3] ##1 c_ds [*3] |-> data_lane_oe_n_out)
        else $error("Bus driven during a write burst.");
    a_read_burst_drives: assert property (c_rd ##1 c_bu [*6] |-> output_en_n_in || !data_lane_oe_n_out)
        else $error("Read burst left the bus undriven.");
    a_overflow_sticks: assert property (rd_overflow_out |=> rd_overflow_out)
        else $error("Overflow flag cleared without reset.");
    a_stall_keeps_word: assert property (rd_valid_out && !rd_ready_in |=> rd_valid_out && $stable(rd_data_out))
        else $error("Read stream word changed while stalled.");
    c_read_burst: cover property (c_rd ##1 c_bu [*3]);
    c_held_run: cover property (clk_en_n_in [*3]);
    c_overflow: cover property (rd_overflow_out);
endmodule
